// ---- hdl/sep_cfg.svh ----
`ifndef SEP_CFG_SVH
`define SEP_CFG_SVH
// Array geometry
`define SEP_PAGE_BYTES 32
`define SEP_PAGE_COUNT 256
`define SEP_ARRAY_BYTES 8192
// Select byte device type codes
`define SEP_TYPE_MAIN 4'hA
`define SEP_TYPE_ID 4'hB
// Address bit that picks lock versus write on the identification page
`define SEP_ID_LOCK_BIT 10
// Clock rates and write cycle time
`define SEP_CLK_KHZ 40000
`define SEP_SCL_MAX_KHZ 1000
`define SEP_TWR_MS 4
`define SEP_TWR_CYCLES (`SEP_TWR_MS * `SEP_CLK_KHZ)
// Register offsets and reset values
`define SEP_REG_CTRL 8'h00
`define SEP_REG_STATUS 8'h04
`define SEP_REG_ADDR 8'h08
`define SEP_CTRL_RST 1'b1
`endif

// ---- hdl/sep_pkg.sv ----
package sep_pkg;
	// Link engine states, one-hot
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_SEL = 7'h02,
		S_AHI = 7'h04,
		S_ALO = 7'h08,
		S_WDATA = 7'h10,
		S_RDATA = 7'h20,
		S_SKIP = 7'h40
	} sep_state_e;
	// Wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
	} sep_wb_req_s;
	// Wishbone answer to the master
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} sep_wb_rsp_s;
	// Decoded select byte
	typedef struct packed {
		logic hit;
		logic id_page;
		logic rd;
	} sep_sel_s;
endpackage : sep_pkg

// ---- hdl/sep_eeprom_slave.sv ----
// Functional notes
// - Serial clock captures incoming data bits and times outgoing data bits.
// - Data line is open-drain only: pull low or release.
// - Strap inputs must equal select code bits b3, b2, b1 to respond.
// - Unconnected strap inputs count as logic 0.
// - Write-protect high blocks every write to the whole array.
// - Write-protect low or unconnected permits array writes.
// - Write-protect high: select and address bytes acked, data bytes not.
// - Main array is 256 pages of 32 bytes.
// - Extra 32-byte identification page, permanently read-only once locked; here id_lock_q is cleared by reset.
// - Bus clock rate up to 1 MHz; master never exceeds it.
// - Select acked only with type 1010b (array) or 1011b (identification page).
// - Select byte bit 0: 1 is read, 0 is write.
// - After each byte transmitter releases; receiver pulls low on ninth pulse.
// - Stop ending a write instruction starts the internal write cycle.
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`include "sep_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_slave #(
	parameter int TWR_CYCLES = `SEP_TWR_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire sep_pkg::sep_wb_req_s wb_req_i,
	output var sep_pkg::sep_wb_rsp_s wb_rsp_o,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oen_o,
	input wire logic strap_select_hi_i,
	input wire logic strap_select_mid_i,
	input wire logic strap_select_lo_i,
	input wire logic write_protect_input_i
);
	import sep_pkg::*;
	localparam int TW = $clog2(TWR_CYCLES + 1);

	// Commit walks the 32 buffered bytes inside the write cycle
	if (TWR_CYCLES < `SEP_PAGE_BYTES + 2) begin : g_bad_twr
		$error("TWR_CYCLES too small for page commit");
	end

	logic [7:0] mem_q [0:`SEP_ARRAY_BYTES-1];
	logic [7:0] idmem_q [0:`SEP_PAGE_BYTES-1];
	logic [7:0] pbuf_q [0:`SEP_PAGE_BYTES-1];
	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	logic [2:0] strap_m_q, strap_s_q;
	logic wp_m_q, wp_s_q, link_clr_q;
	logic [7:0] shreg_q, shreg_d, rd_q, rd_d, byte_now;
	sep_state_e st_q, st_d;
	logic [3:0] bit_q, bit_d;
	logic [12:0] addr_q, addr_d;
	logic idp_q, idp_d, lkadr_q, lkadr_d, lockp_q, lockp_d, id_lock_q, id_lock_d;
	logic drive_q, drive_d, busy_q, busy_d, en_q, en_d, drv_q, drv_d;
	logic [31:0] mask_q, mask_d;
	logic [TW-1:0] twr_q, twr_d;
	logic rise, start_c, stop_c, pb_we, ack_c;
	sep_sel_s sel_c;
	sep_wb_rsp_s rsp_d;

	// Decode a select byte against type codes and strap code
	function automatic sep_sel_s decode_sel(input logic [7:0] b, input logic [2:0] strap);
		sep_sel_s r;
		r.id_page = (b[7:4] == `SEP_TYPE_ID);
		r.hit = ((b[7:4] == `SEP_TYPE_MAIN) || r.id_page) && (b[3:1] == strap);
		r.rd = b[0];
		return r;
	endfunction : decode_sel

	// Fetch the byte a read returns from array or identification page
	function automatic logic [7:0] fetch(input logic id, input logic [12:0] a);
		return id ? idmem_q[a[4:0]] : mem_q[a];
	endfunction : fetch

	// Next address after a read; the identification page wraps within itself
	function automatic logic [12:0] next_addr(input logic id, input logic [12:0] a);
		return id ? {a[12:5], a[4:0] + 5'h01} : a + 13'h0001;
	endfunction : next_addr

	// Link side: shift on rising, drive on falling serial clock
	always_comb begin
		shreg_d = {shreg_q[6:0], sda_i};
		drv_d = drive_q;
	end
	always_ff @(posedge scl_i or posedge link_clr_q) begin
		if (link_clr_q) begin
			shreg_q <= 8'h00;
		end else begin
			shreg_q <= shreg_d;
		end
	end
	always_ff @(negedge scl_i or posedge link_clr_q) begin
		if (link_clr_q) begin
			drv_q <= 1'b0;
		end else begin
			drv_q <= drv_d;
		end
	end
	// Only ever pull low; enable is low while pulling
	assign sda_o = 1'b0;
	assign sda_oen_o = ~drv_q;

	// Pin synchronisers; straps and protect pin have pad pull-downs
	always_ff @(posedge ref_clk_i) begin
		link_clr_q <= ~rstn_i;
		scl_m_q <= scl_i;
		scl_s_q <= scl_m_q;
		scl_p_q <= scl_s_q;
		sda_m_q <= sda_i;
		sda_s_q <= sda_m_q;
		sda_p_q <= sda_s_q;
		strap_m_q <= {strap_select_hi_i, strap_select_mid_i, strap_select_lo_i};
		strap_s_q <= strap_m_q;
		wp_m_q <= write_protect_input_i;
		wp_s_q <= wp_m_q;
	end

	// Bus events seen through the synchronisers
	assign rise = scl_s_q & ~scl_p_q;
	assign start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	// Shift register is stable for a whole bit after the rise it took
	assign byte_now = shreg_q;
	assign sel_c = decode_sel(byte_now, strap_s_q);

	// Protocol engine and write cycle control
	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		addr_d = addr_q;
		rd_d = rd_q;
		idp_d = idp_q;
		lkadr_d = lkadr_q;
		lockp_d = lockp_q;
		id_lock_d = id_lock_q;
		drive_d = drive_q;
		busy_d = busy_q;
		mask_d = mask_q;
		twr_d = twr_q;
		pb_we = 1'b0;
		ack_c = 1'b0;
		if (busy_q) begin
			twr_d = twr_q + TW'(1);
			if (twr_q == TW'(TWR_CYCLES - 1)) begin
				busy_d = 1'b0;
				mask_d = 32'h0000_0000;
				twr_d = '0;
			end
		end
		if (stop_c) begin
			st_d = S_IDLE;
			drive_d = 1'b0;
			if (!busy_q) begin
				mask_d = 32'h0000_0000;
				lockp_d = 1'b0;
				if ((mask_q != 32'h0000_0000) || lockp_q) begin
					busy_d = 1'b1;
					twr_d = '0;
					id_lock_d = id_lock_q | lockp_q;
					mask_d = mask_q;
				end
			end
		end else if (start_c) begin
			st_d = (busy_q || !en_q) ? S_SKIP : S_SEL;
			bit_d = 4'h0;
			drive_d = 1'b0;
		end else if (rise && (st_q != S_IDLE) && (st_q != S_SKIP)) begin
			bit_d = (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
			if (st_q == S_RDATA) begin
				if (bit_q < 4'h7) begin
					drive_d = ~rd_q[3'h6 - bit_q[2:0]];
				end else if (bit_q == 4'h7) begin
					drive_d = 1'b0;
				end else if (!byte_now[0]) begin
					rd_d = fetch(idp_q, addr_q);
					addr_d = next_addr(idp_q, addr_q);
					drive_d = ~rd_d[7];
				end else begin
					st_d = S_SKIP;
				end
			end else if (bit_q == 4'h7) begin
				case (st_q)
					S_SEL: begin
						ack_c = sel_c.hit;
						idp_d = sel_c.id_page;
					end
					S_AHI: begin
						ack_c = 1'b1;
						addr_d[12:8] = byte_now[4:0];
						lkadr_d = byte_now[`SEP_ID_LOCK_BIT - 8];
					end
					S_ALO: begin
						ack_c = 1'b1;
						addr_d[7:0] = byte_now;
					end
					default: begin
						ack_c = !wp_s_q && !(idp_q && id_lock_q);
						if (ack_c && idp_q && lkadr_q) begin
							lockp_d = 1'b1;
						end else if (ack_c) begin
							pb_we = 1'b1;
							mask_d[addr_q[4:0]] = 1'b1;
							addr_d[4:0] = addr_q[4:0] + 5'h01;
						end
					end
				endcase
				drive_d = ack_c;
			end else if (bit_q == 4'h8) begin
				drive_d = 1'b0;
				if (!drive_q) begin
					st_d = S_SKIP;
				end else begin
					case (st_q)
						S_SEL: begin
							if (byte_now[1]) begin
								st_d = S_RDATA;
								rd_d = fetch(idp_q, addr_q);
								addr_d = next_addr(idp_q, addr_q);
								drive_d = ~rd_d[7];
							end else begin
								st_d = S_AHI;
								if (!busy_q) begin
									mask_d = 32'h0000_0000;
									lockp_d = 1'b0;
								end
							end
						end
						S_AHI: st_d = S_ALO;
						S_ALO: st_d = S_WDATA;
						default: st_d = S_WDATA;
					endcase
				end
			end
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			st_q <= S_IDLE;
			bit_q <= 4'h0;
			addr_q <= 13'h0000;
			rd_q <= 8'h00;
			idp_q <= 1'b0;
			lkadr_q <= 1'b0;
			lockp_q <= 1'b0;
			id_lock_q <= 1'b0;
			drive_q <= 1'b0;
			busy_q <= 1'b0;
			mask_q <= 32'h0000_0000;
			twr_q <= '0;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
			idp_q <= idp_d;
			lkadr_q <= lkadr_d;
			lockp_q <= lockp_d;
			id_lock_q <= id_lock_d;
			drive_q <= drive_d;
			busy_q <= busy_d;
			mask_q <= mask_d;
			twr_q <= twr_d;
		end
	end

	// Page buffer fill and commit into the arrays during the write cycle
	always_ff @(posedge ref_clk_i) begin
		if (pb_we) begin
			pbuf_q[addr_q[4:0]] <= byte_now;
		end
		if (busy_q && (twr_q < TW'(`SEP_PAGE_BYTES)) && mask_q[twr_q[4:0]]) begin
			if (idp_q) begin
				idmem_q[twr_q[4:0]] <= pbuf_q[twr_q[4:0]];
			end else begin
				mem_q[{addr_q[12:5], twr_q[4:0]}] <= pbuf_q[twr_q[4:0]];
			end
		end
	end

	// Wishbone slave: one-cycle ack, unmapped reads return zero
	always_comb begin
		en_d = en_q;
		rsp_d.ack = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
		rsp_d.dat = 32'h0000_0000;
		if (wb_req_i.adr == `SEP_REG_CTRL) begin
			rsp_d.dat = {31'h0000_0000, en_q};
			if (wb_rsp_o.ack && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0]) begin
				en_d = wb_req_i.dat[0];
			end
		end else if (wb_req_i.adr == `SEP_REG_STATUS) begin
			rsp_d.dat = {28'h0000_000, wp_s_q, (st_q != S_IDLE) && (st_q != S_SKIP), id_lock_q, busy_q};
		end else if (wb_req_i.adr == `SEP_REG_ADDR) begin
			rsp_d.dat = {19'h0_0000, addr_q};
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			en_q <= `SEP_CTRL_RST;
			wb_rsp_o <= '0;
		end else begin
			en_q <= en_d;
			wb_rsp_o <= rsp_d;
		end
	end

	// Checks on the protocol engine
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	wire at_byte = rise && !stop_c && !start_c && (bit_q == 4'h7);
	chk_select_nack: assert property (at_byte && (st_q == S_SEL) && !sel_c.hit |=> !drive_q)
		else $error("select byte with wrong code was acknowledged");
	chk_select_ack: assert property (at_byte && (st_q == S_SEL) && sel_c.hit |=> drive_q ##1 drive_q)
		else $error("matching select byte not acknowledged");
	chk_addr_ack: assert property (at_byte && ((st_q == S_AHI) || (st_q == S_ALO)) |=> drive_q)
		else $error("address byte not acknowledged");
	chk_protect_nack: assert property (at_byte && (st_q == S_WDATA) && wp_s_q |=> !drive_q)
		else $error("data byte acknowledged while protected");
	chk_protect_keep: assert property (at_byte && (st_q == S_WDATA) && wp_s_q |=> mask_q == $past(mask_q))
		else $error("protected data byte entered the page buffer");
	chk_stop_commit: assert property (stop_c && !busy_q && (mask_q != 32'h0000_0000) |=> busy_q && (twr_q == '0))
		else $error("stop after write did not start write cycle");
	chk_stop_idle: assert property (stop_c && !busy_q && (mask_q == 32'h0000_0000) && !lockp_q |=> !busy_q)
		else $error("write cycle started with nothing accepted");
	chk_lock_sticky: assert property ($rose(id_lock_q) |=> id_lock_q [*8])
		else $error("identification lock was released");
	chk_read_dir: assert property (rise && !stop_c && !start_c && (bit_q == 4'h8) && (st_q == S_SEL) && drive_q && byte_now[1]
		|=> st_q == S_RDATA)
		else $error("read select did not enter read state");
	chk_ack_release: assert property (rise && !stop_c && !start_c && (bit_q == 4'h8) && (st_q == S_AHI) |=> !drive_q)
		else $error("data line held after acknowledge bit");
	chk_open_drain: assert property ($fell(sda_oen_o) |-> (sda_o == 1'b0) && drive_q)
		else $error("data line pulled low without a decision to pull");
	cov_select: cover property (at_byte && (st_q == S_SEL) && sel_c.hit);
	cov_commit: cover property (stop_c && !busy_q && (mask_q != 32'h0000_0000));
	cov_read: cover property ((st_q == S_RDATA) && rise && (bit_q == 4'h8));
	cov_protect: cover property (at_byte && (st_q == S_WDATA) && wp_s_q);
endmodule : sep_eeprom_slave
`default_nettype wire

// ---- testbench/sep_link_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-wire bus master model, paced by the link clock
module sep_link_master (
	input wire logic lclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o,
	output logic vld_o,
	output logic [7:0] val_o
);
	int hp = 7;
	// Idle bus: both lines released, clock stands still
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		vld_o = 1'b0;
		val_o = 8'h00;
	end
	// Wait link ticks; seven ticks a half keeps the bus under 1 MHz
	task tk(input int n);
		repeat (n) @(posedge lclk_i);
	endtask : tk
	// Start or repeated start: data falls while the clock is high
	task st();
		sda_o <= 1'b1;
		tk(hp);
		scl_o <= 1'b1;
		tk(hp);
		sda_o <= 1'b0;
		tk(hp);
		scl_o <= 1'b0;
		tk(2);
	endtask : st
	// One bit: data set while the clock is low, line read while high
	task bt(input logic b, output logic r);
		sda_o <= b;
		tk(hp);
		scl_o <= 1'b1;
		tk(hp);
		r = sda_i;
		scl_o <= 1'b0;
		tk(2);
	endtask : bt
	// Byte, MSB first, then the ninth bit; publishes the ack or the byte read
	task x(input logic [7:0] d, input logic mack, input logic rd);
		logic [7:0] r;
		logic a;
		for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
		bt(mack, a);
		val_o <= rd ? r : {7'h00, a};
		vld_o <= 1'b1;
		tk(1);
		vld_o <= 1'b0;
	endtask : x
	// Stop: data rises while the clock is high
	task sp();
		sda_o <= 1'b0;
		tk(hp);
		scl_o <= 1'b1;
		tk(hp);
		sda_o <= 1'b1;
		tk(hp);
	endtask : sp
endmodule : sep_link_master
`default_nettype wire

// ---- testbench/sep_eeprom_slave_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_slave_bench;
	import sep_pkg::*;
	logic clk, rst_n, lclk, scl, msda, line, sdo, oen, vld, wp;
	logic [2:0] strap;
	logic [7:0] val, ah, al, dv;
	logic [31:0] rd;
	logic [3:0] ty [4] = '{4'hA, 4'hB, 4'h9, 4'h2};
	sep_wb_req_s req;
	sep_wb_rsp_s rsp;
	logic [63:0] q [$];
	int n_mismatch, n_checks, seed, tst, n, m;
	// System clock 25 ns, link clock 80 ns with an unrelated phase
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #40 lclk = ~lclk;
	end
	// Open-drain wire with pull-up
	assign line = (oen ? 1'b1 : sdo) & msda;
	sep_eeprom_slave #(.TWR_CYCLES(64)) sep_eeprom_slave_i (.ref_clk_i(clk), .rstn_i(rst_n), .wb_req_i(req),
		.wb_rsp_o(rsp), .scl_i(scl), .sda_i(line), .sda_o(sdo), .sda_oen_o(oen), .strap_select_hi_i(strap[2]),
		.strap_select_mid_i(strap[1]), .strap_select_lo_i(strap[0]), .write_protect_input_i(wp));
	sep_link_master sep_link_master_i (.lclk_i(lclk), .sda_i(line), .scl_o(scl), .sda_o(msda), .vld_o(vld),
		.val_o(val));
	task tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task to();
		n_mismatch++;
		$display("MISMATCH %0t wait ran out", $time);
		tally_and_finish();
	endtask : to
	// Note an expected value under a mask
	task nt(input logic [31:0] m, input logic [31:0] e);
		q.push_back({m, e & m});
	endtask : nt
	// Oldest note against a result
	task cmp(input logic [31:0] got);
		logic [63:0] e;
		e = q.pop_front();
		n_checks++;
		if ((got & e[63:32]) !== e[31:0]) begin
			n_mismatch++;
			$display("MISMATCH %0t test %0d got %h exp %h", $time, tst, got, e[31:0]);
		end
	endtask : cmp
	// Watch read answers on both interfaces
	always @(posedge clk) if (rsp.ack === 1'b1 && req.we === 1'b0 && q.size() > 0) cmp(rsp.dat);
	always @(negedge vld) if (q.size() > 0) cmp({24'h000000, val});
	// Classic single cycle, held until ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, dat: d, sel: 4'hF};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.ack !== 1'b1 && n < 50);
		rd = rsp.dat;
		req <= '0;
		if (n >= 50) to();
	endtask : wb
	// One link byte with its expected ack or data
	task lk(input logic [7:0] d, input logic [7:0] e, input logic r);
		nt(32'h000000FF, {24'h000000, e});
		sep_link_master_i.x(d, 1'b1, r);
	endtask : lk
	// Poll status until the write cycle ends
	task pw();
		m = 0;
		do begin
			wb(1'b0, 8'h04, 32'h0);
			m++;
		end while (rd[0] !== 1'b0 && m < 100);
		if (m >= 100) to();
	endtask : pw
	// Select, address and one data byte, then stop
	task wr(input logic [3:0] t, input logic [7:0] e);
		sep_link_master_i.st();
		lk({t, strap, 1'b0}, 8'h00, 1'b0);
		lk(ah, 8'h00, 1'b0);
		lk(al, 8'h00, 1'b0);
		lk(dv, e, 1'b0);
		sep_link_master_i.sp();
	endtask : wr
	// Random address read of one byte
	task rb(input logic [3:0] t, input logic [7:0] e);
		sep_link_master_i.st();
		lk({t, strap, 1'b0}, 8'h00, 1'b0);
		lk(ah, 8'h00, 1'b0);
		lk(al, 8'h00, 1'b0);
		sep_link_master_i.st();
		lk({t, strap, 1'b1}, 8'h00, 1'b0);
		lk(8'hFF, e, 1'b1);
		sep_link_master_i.sp();
	endtask : rb
	// Main sequence
	initial begin
		seed = 50443;
		n_mismatch = 0;
		n_checks = 0;
		rst_n = 1'b0;
		req = '0;
		wp = 1'b0;
		strap = 3'h0;
		tst = 1;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		nt(32'h00000001, 32'h00000001);
		wb(1'b0, 8'h00, 32'h0);
		nt(32'hFFFFFFFF, 32'h0);
		wb(1'b0, 8'h3C, 32'h0);
		$display("test %0d done", tst);
		for (int p = 0; p < 2; p++) begin
			tst = 2 + p;
			@(posedge clk);
			strap <= (p == 0) ? 3'h0 : 3'($random(seed));
			repeat (4) @(posedge clk);
			for (int i = 0; i < 7; i++) begin
				sep_link_master_i.st();
				if (i < 4) lk({ty[i], strap, 1'b0}, {7'h00, ty[i][3:1] != 3'b101}, 1'b0);
				else lk({4'hA, strap ^ 3'(1 << (i - 4)), 1'b0}, 8'h01, 1'b0);
				sep_link_master_i.sp();
			end
			$display("test %0d done", tst);
		end
		tst = 4;
		ah = 8'($random(seed)) & 8'h1F;
		al = 8'($random(seed));
		dv = 8'($random(seed));
		wr(4'hA, 8'h00);
		nt(32'h00000001, 32'h00000001);
		wb(1'b0, 8'h04, 32'h0);
		pw();
		rb(4'hA, dv);
		nt(32'h00001FFF, {19'h0, ah[4:0], al} + 32'h1);
		wb(1'b0, 8'h08, 32'h0);
		$display("test %0d done", tst);
		tst = 5;
		sep_link_master_i.hp = 12;
		@(posedge clk);
		wp <= 1'b1;
		repeat (4) @(posedge clk);
		dv = ~dv;
		wr(4'hA, 8'h01);
		nt(32'h00000009, 32'h00000008);
		wb(1'b0, 8'h04, 32'h0);
		rb(4'hA, ~dv);
		$display("test %0d done", tst);
		// Identification page: write, read back, lock, then a refused write
		tst = 6;
		sep_link_master_i.hp = 7;
		@(posedge clk);
		wp <= 1'b0;
		repeat (4) @(posedge clk);
		ah = 8'h00;
		wr(4'hB, 8'h00);
		pw();
		rb(4'hB, dv);
		ah = 8'h04;
		wr(4'hB, 8'h00);
		pw();
		ah = 8'h00;
		dv = ~dv;
		wr(4'hB, 8'h01);
		nt(32'h00000003, 32'h00000002);
		wb(1'b0, 8'h04, 32'h0);
		rb(4'hB, ~dv);
		$display("test %0d done", tst);
		// Respond enable off: a matching select is ignored
		tst = 7;
		wb(1'b1, 8'h00, 32'h0);
		sep_link_master_i.st();
		lk({4'hA, strap, 1'b0}, 8'h01, 1'b0);
		sep_link_master_i.sp();
		wb(1'b1, 8'h00, 32'h1);
		nt(32'h00000001, 32'h00000001);
		wb(1'b0, 8'h00, 32'h0);
		sep_link_master_i.st();
		lk({4'hA, strap, 1'b0}, 8'h00, 1'b0);
		sep_link_master_i.sp();
		$display("test %0d done", tst);
		tally_and_finish();
	end
endmodule : sep_eeprom_slave_bench
`default_nettype wire
